//--- verilog/pcd_defs.svh
// constants for the panel command decoder
`ifndef PCD_DEFS_SVH
`define PCD_DEFS_SVH
`define PCD_FAM_CONFIG      2'h0
`define PCD_FAM_DATA        2'h1
`define PCD_FAM_DISP        2'h2
`define PCD_FAM_ADDR        2'h3
`define PCD_GRP_WRITE       2'h0
`define PCD_GRP_RSVD        2'h1
`define PCD_GRP_READ1       2'h2
`define PCD_GRP_READ2       2'h3
`define PCD_ADDR_RESET      6'h10
`define PCD_ADDR_RTC_LAST   6'h0F
`define PCD_RC_BYTES        5'h10
`define PCD_KEY_BYTES       5'h03
`define PCD_SEG_BYTES       5'h07
`define PCD_SEG_MAP_BYTES   5'h06
`define PCD_DIM_RESET       3'h0
`endif

//--- verilog/pcd_pkg.sv
// types shared by the panel command decoder
package pcd_pkg;
	typedef enum logic [2:0] {
		PCD_DST_MEM,
		PCD_DST_LED,
		PCD_RD_KEY,
		PCD_RD_SWITCH,
		PCD_RD_REMOTE,
		PCD_RD_IRQ,
		PCD_RD_CONFIG,
		PCD_RD_CLOCK
	} pcd_dir_t;

	typedef struct packed {
		logic [7:0] data;
		logic       is_first;
		logic       valid;
	} pcd_byte_t;

	typedef struct packed {
		logic       sep_digit;
		logic       show_sec;
		logic       show_ampm;
	} pcd_fmt_t;
endpackage : pcd_pkg

//--- verilog/pcd_decoder.sv
// command byte decoder for the front panel controller
//
// Function
// - first byte after address is a command
// - 00h-0Fh clock, 10h-3Fh display memory
// - top bits 01 decode data setting
// - bits 5:4 pick write or read group
// - bit 3 restarts guard timer count
// - bit 2 selects fixed or incrementing address
// - write codes 00 memory, 11 led port
// - write codes 01/10 enter/leave test mode
// - read group one selects returned data
// - read group two: config or clock data
// - reset: normal display, increment, address 10h
// - top bits 10 decode display control
// - bits 2:0 set eight dimming steps
// - bit 3 switches display, scanning continues
// - remote hotkey pairs, up to sixteen bytes
// - shorter remote hotkey stream is accepted
// - three bytes mark front panel hotkeys
// - bit pairs map scan lines in order
// - seven bytes: six maps and format
// - segment code is index minus one
// - fixed segment pair order per byte
// - format bit 6 selects separator digit
// - format bits 5/4 seconds and am/pm
`timescale 1ns/1ps
`include "pcd_defs.svh"

module pcd_decoder
	import pcd_pkg::*;
#(
	parameter int RC_BYTES = 16
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	// bytes from the serial slave, already on sys_clk
	input  wire pcd_byte_t        rx_byte,
	// mode outputs
	output logic                  test_mode_q,
	output pcd_dir_t              direction_q,
	output logic                  fixed_addr_q,
	output logic [5:0]            mem_addr_q,
	output logic                  clock_space_q,
	output logic                  guard_restart_q,
	// display control outputs
	output logic [2:0]            dim_code_q,
	output logic                  display_on_q,
	// hotkey and clock display configuration
	output logic [8*RC_BYTES-1:0] remote_hotkeys_q,
	output logic [4:0]            remote_count_q,
	output logic [23:0]           panel_hotkeys_q,
	output logic [47:0]           segment_map_q,
	output pcd_fmt_t              clock_fmt_q
);

	typedef enum logic [1:0] {
		PCD_ST_IDLE,
		PCD_ST_REMOTE,
		PCD_ST_PANEL,
		PCD_ST_SEGMENT
	} pcd_load_t;

	pcd_load_t  load_q;
	logic [4:0] idx_q;
	logic       cmd_ok_q;
	logic       grp_legal;
	logic       is_cmd;
	logic       is_data;
	logic [1:0] fam;
	logic [1:0] grp;
	logic [1:0] low;
	logic [7:0] b;

	// a byte is a command only when it follows the slave address
	// command after address
	assign b       = rx_byte.data;
	assign is_cmd  = rx_byte.valid && rx_byte.is_first;
	assign is_data = rx_byte.valid && !rx_byte.is_first && cmd_ok_q;
	assign fam     = b[7:6];
	assign grp     = b[5:4];
	assign low     = b[1:0];

	// reserved read-two codes must not restart the guard timer either
	// reserved data codes excluded
	assign grp_legal = grp != `PCD_GRP_RSVD && !(grp == `PCD_GRP_READ2 && !low[0]);

	// data bytes only count once a command has opened the transfer
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cmd_ok_q <= 1'b0;
		end else if (is_cmd) begin
			cmd_ok_q <= 1'b1;
		end
	end

	// data setting command: direction and addressing mode
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			direction_q  <= PCD_DST_MEM;
			fixed_addr_q <= 1'b0;
			test_mode_q  <= 1'b0;
		end else if (is_cmd && fam == `PCD_FAM_DATA && grp != `PCD_GRP_RSVD) begin
			// group select, 01 skipped as reserved
			unique case (grp)
				`PCD_GRP_WRITE: begin
					fixed_addr_q <= b[2];
					unique case (low)
						2'h0: direction_q <= PCD_DST_MEM;
						2'h3: direction_q <= PCD_DST_LED;
						2'h1: test_mode_q <= 1'b1;
						2'h2: test_mode_q <= 1'b0;
					endcase
				end
				`PCD_GRP_READ1: begin
					fixed_addr_q <= b[2];
					unique case (low)
						2'h0: direction_q <= PCD_RD_KEY;
						2'h1: direction_q <= PCD_RD_SWITCH;
						2'h2: direction_q <= PCD_RD_REMOTE;
						2'h3: direction_q <= PCD_RD_IRQ;
					endcase
				end
				default: begin
					if (low[0]) begin
						fixed_addr_q <= b[2];
						direction_q  <= low[1] ? PCD_RD_CLOCK : PCD_RD_CONFIG;
					end
				end
			endcase
		end
	end

	// guard timer restart is a one-cycle pulse; the time value lives elsewhere
	// restart without changing guard time
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			guard_restart_q <= 1'b0;
		end else begin
			guard_restart_q <= is_cmd && fam == `PCD_FAM_DATA && grp_legal && b[3];
		end
	end

	// memory address: set by address command, stepped by written data
	// address space split
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			mem_addr_q <= `PCD_ADDR_RESET;
		end else if (is_cmd && fam == `PCD_FAM_ADDR) begin
			mem_addr_q <= b[5:0];
		// stream steps the address, no repeat command needed
		end else if (is_data && load_q == PCD_ST_IDLE && direction_q == PCD_DST_MEM
				&& !fixed_addr_q) begin
			mem_addr_q <= mem_addr_q + 6'h01;
		end
	end

	// registered so the output comes straight from a flip-flop
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			clock_space_q <= 1'b0;
		end else if (is_cmd && fam == `PCD_FAM_ADDR) begin
			clock_space_q <= b[5:0] <= `PCD_ADDR_RTC_LAST;
		end else begin
			clock_space_q <= mem_addr_q <= `PCD_ADDR_RTC_LAST;
		end
	end

	// dimming and display switch
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			dim_code_q   <= `PCD_DIM_RESET;
			display_on_q <= 1'b0;
		// display control family, bit 4 reserved, bit 3 switches display
		end else if (is_cmd && fam == `PCD_FAM_DISP && !b[5]) begin
			dim_code_q   <= b[2:0];
			display_on_q <= b[3];
		end
	end

	// configuration stream loader; one stream per command, lowest bit wins
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			load_q <= PCD_ST_IDLE;
			idx_q  <= 5'h00;
		end else if (is_cmd) begin
			idx_q <= 5'h00;
			if (fam == `PCD_FAM_DISP && b[5] && b[0]) begin
				load_q <= PCD_ST_REMOTE;
			end else if (fam == `PCD_FAM_DISP && b[5] && b[1]) begin
				load_q <= PCD_ST_PANEL;
			end else if (fam == `PCD_FAM_DISP && b[5] && b[2]) begin
				load_q <= PCD_ST_SEGMENT;
			end else begin
				load_q <= PCD_ST_IDLE;
			end
		end else if (is_data && load_q != PCD_ST_IDLE) begin
			idx_q <= idx_q + 5'h01;
			// stream closes at its full length; extra bytes are not loaded but step the address like memory data
			unique case (load_q)
				PCD_ST_REMOTE:  if (idx_q == 5'(RC_BYTES - 1)) load_q <= PCD_ST_IDLE;
				PCD_ST_PANEL:   if (idx_q == `PCD_KEY_BYTES - 5'h01) load_q <= PCD_ST_IDLE;
				PCD_ST_SEGMENT: if (idx_q == `PCD_SEG_BYTES - 5'h01) load_q <= PCD_ST_IDLE;
				default:        load_q <= PCD_ST_IDLE;
			endcase
		end
	end

	// remote hotkeys: byte n at bits 8n up, address then command
	// address/command pairs, LSB aligned
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			remote_hotkeys_q <= '0;
			remote_count_q   <= 5'h00;
		end else if (is_cmd && fam == `PCD_FAM_DISP && b[5] && b[0]) begin
			// count restarts, a short stream is valid
			remote_count_q <= 5'h00;
		end else if (is_data && load_q == PCD_ST_REMOTE) begin
			remote_hotkeys_q[8*idx_q +: 8] <= b;
			remote_count_q                 <= idx_q + 5'h01;
		end
	end

	// front panel hotkeys: bit 2k is scan line k+1 first key
	// three hotkey bytes
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			panel_hotkeys_q <= '0;
		end else if (is_data && load_q == PCD_ST_PANEL) begin
			panel_hotkeys_q[8*idx_q +: 8] <= b;
		end
	end

	// segment map bytes then format byte
	// six maps and a format byte
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			segment_map_q <= '0;
			clock_fmt_q   <= '0;
		end else if (is_data && load_q == PCD_ST_SEGMENT) begin
			if (idx_q < `PCD_SEG_MAP_BYTES) begin
				// pair order kept by byte position; r and n have no slot
				segment_map_q[8*idx_q +: 8] <= b;
			end else begin
				clock_fmt_q.sep_digit <= b[6];
				clock_fmt_q.show_sec  <= b[5];
				clock_fmt_q.show_ampm <= b[4];
			end
		end
	end

	// address back at 10h one edge after reset
	a_reset_addr: assert property (@(posedge sys_clk)
		$rose(resetn) |-> mem_addr_q == `PCD_ADDR_RESET)
		else $error("address not 10h after reset");

	// orphan data never moves the address
	a_orphan_data: assert property (@(posedge sys_clk) disable iff (!resetn)
		(rx_byte.valid && !rx_byte.is_first && !cmd_ok_q) |=> $stable(mem_addr_q))
		else $error("data without command took effect");

	// restart pulse follows bit 3 of a data command
	a_guard_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_cmd && b[7:6] == 2'h1 && b[5:4] == 2'h0 && b[3]) |=> guard_restart_q)
		else $error("guard restart missing");

	a_rsvd_group: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_cmd && b[7:4] == 4'h5) |=> $stable(direction_q) && $stable(fixed_addr_q))
		else $error("reserved group changed state");

	a_led_dir: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_cmd && b[7:4] == 4'h4 && b[1:0] == 2'h3) |=> direction_q == PCD_DST_LED)
		else $error("led direction not taken");

	// dimming code taken from control command
	a_dim_load: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_cmd && b[7:5] == 3'h4) |=> dim_code_q == $past(b[2:0]) && display_on_q == $past(b[3]))
		else $error("dimming or display bit not loaded");

	// incrementing mode steps address by one per memory byte
	a_addr_step: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_data && load_q == PCD_ST_IDLE && direction_q == PCD_DST_MEM && !fixed_addr_q)
		|=> mem_addr_q == $past(mem_addr_q) + 6'h01)
		else $error("auto increment failed");

	// panel stream ends after three bytes
	a_panel_len: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_data && load_q == PCD_ST_PANEL && idx_q == 5'h02) |=> load_q == PCD_ST_IDLE)
		else $error("panel stream did not close");

	// reserved read-two codes give no restart pulse
	a_rsvd_guard: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_cmd && b[7:4] == 4'h7 && !b[0]) |=> !guard_restart_q)
		else $error("reserved code restarted guard timer");

	// address command sets the clock window flag at once
	a_clock_space: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_cmd && b[7:6] == 2'h3) |=> clock_space_q == ($past(b[5:0]) <= 6'h0F))
		else $error("clock window flag wrong");

	// hotkey commands leave dimming and display alone
	a_disp_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_cmd && b[7:5] == 3'h5) |=> $stable(dim_code_q) && $stable(display_on_q))
		else $error("hotkey command changed display control");

	// remote count follows the bytes received
	a_remote_count: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_data && load_q == PCD_ST_REMOTE) |=> remote_count_q == $past(idx_q) + 5'h01)
		else $error("remote byte count wrong");

	// clock stream closes after its format byte
	a_seg_close: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_data && load_q == PCD_ST_SEGMENT && idx_q == 5'h06) |=> load_q == PCD_ST_IDLE)
		else $error("segment stream did not close");

	// test entry code sets test mode
	a_test_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_cmd && b[7:4] == 4'h4 && b[1:0] == 2'h1) |=> test_mode_q)
		else $error("test mode not entered");

	// a command opens the transfer for data bytes
	a_cmd_open: assert property (@(posedge sys_clk) disable iff (!resetn)
		is_cmd |=> cmd_ok_q)
		else $error("command did not open transfer");

endmodule : pcd_decoder

//--- dv/pcd_host_model.sv
// host-side byte source that stands in for the serial master
`timescale 1ns/1ps
module pcd_host_model
	import pcd_pkg::*;
(
	// clock
	input  wire logic sys_clk,
	// received bytes towards the decoder
	output pcd_byte_t rx_byte
);
	// idle line shows no stale byte
	initial rx_byte = '0;

	// one byte, valid for a single cycle, launched just after the edge
	task automatic put(input logic [7:0] b, input logic first);
		@(posedge sys_clk);
		#1;
		rx_byte = '{data: b, is_first: first, valid: 1'b1};
		@(posedge sys_clk);
		#1;
		rx_byte = '{data: ~b, is_first: 1'b0, valid: 1'b0}; // inverted so stale data never matches
	endtask : put

	// one command then its data bytes
	task automatic stream(input logic [7:0] cmd, input logic [7:0] d[$]);
		put(cmd, 1'b1);
		foreach (d[i]) put(d[i], 1'b0);
	endtask : stream
endmodule : pcd_host_model

//--- dv/panel_command_decoder_tb.sv
// self-checking bench for the panel command decoder
`timescale 1ns/1ps
module panel_command_decoder_tb
	import pcd_pkg::*;
;
	logic             sys_clk;
	logic             resetn;
	pcd_byte_t        rx_byte;
	logic             test_mode_q, fixed_addr_q, clock_space_q, guard_restart_q, display_on_q;
	pcd_dir_t         direction_q;
	logic [5:0]       mem_addr_q;
	logic [2:0]       dim_code_q;
	logic [127:0]     remote_hotkeys_q;
	logic [4:0]       remote_count_q;
	logic [23:0]      panel_hotkeys_q;
	logic [47:0]      segment_map_q;
	pcd_fmt_t         clock_fmt_q;
	int               miscompares = 0;
	int               cmp_count = 0;

	pcd_decoder #(.RC_BYTES(16)) dut (.sys_clk(sys_clk), .resetn(resetn), .rx_byte(rx_byte),
		.test_mode_q(test_mode_q), .direction_q(direction_q), .fixed_addr_q(fixed_addr_q),
		.mem_addr_q(mem_addr_q), .clock_space_q(clock_space_q),
		.guard_restart_q(guard_restart_q), .dim_code_q(dim_code_q),
		.display_on_q(display_on_q), .remote_hotkeys_q(remote_hotkeys_q),
		.remote_count_q(remote_count_q), .panel_hotkeys_q(panel_hotkeys_q),
		.segment_map_q(segment_map_q), .clock_fmt_q(clock_fmt_q));
	pcd_host_model host (.sys_clk(sys_clk), .rx_byte(rx_byte));

	// 100 ns clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// the one compare: four-state equality so unknowns fail
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// defaults, then a data byte with no command ahead of it
	task automatic t_reset();
		chk(mem_addr_q, 6'h10);
		chk(direction_q, PCD_DST_MEM);
		chk(fixed_addr_q, 1'b0);
		chk({test_mode_q, display_on_q, dim_code_q}, 5'h00);
		host.put(8'h8F, 1'b0);
		chk(display_on_q, 1'b0);
		chk(mem_addr_q, 6'h10);
		$display("reset test done");
	endtask : t_reset

	// each direction code, then reserved ones leave the target alone
	task automatic t_data();
		logic [7:0] code[8];
		pcd_dir_t   dir[8];
		code = '{8'h40, 8'h43, 8'h60, 8'h61, 8'h62, 8'h63, 8'h71, 8'h73};
		dir = '{PCD_DST_MEM, PCD_DST_LED, PCD_RD_KEY, PCD_RD_SWITCH, PCD_RD_REMOTE,
			PCD_RD_IRQ, PCD_RD_CONFIG, PCD_RD_CLOCK};
		host.put(8'h4C, 1'b1);
		chk(guard_restart_q, 1'b1);
		chk(fixed_addr_q, 1'b1);
		@(posedge sys_clk);
		#1;
		chk(guard_restart_q, 1'b0);
		foreach (code[i]) begin
			host.put(code[i], 1'b1);
			chk(direction_q, dir[i]);
		end
		chk(fixed_addr_q, 1'b0);
		foreach (code[i]) begin
			if (i < 3) begin
				host.put(i == 0 ? 8'h5C : (i == 1 ? 8'h78 : 8'h7E), 1'b1);
				chk(direction_q, PCD_RD_CLOCK);
				chk(guard_restart_q, 1'b0);
			end
		end
		chk(fixed_addr_q, 1'b0);
		$display("data setting test done");
	endtask : t_data

	// production test mode in and out
	task automatic t_test();
		host.put(8'h41, 1'b1);
		chk(test_mode_q, 1'b1);
		host.put(8'h42, 1'b1);
		chk(test_mode_q, 1'b0);
		$display("test mode test done");
	endtask : t_test

	// all eight dimming steps, then display off
	task automatic t_disp();
		for (int c = 0; c < 8; c++) begin
			host.put(8'h88 | 8'(c), 1'b1);
			chk({display_on_q, dim_code_q}, {1'b1, 3'(c)});
		end
		host.put(8'h85, 1'b1);
		chk({display_on_q, dim_code_q}, 4'h5);
		$display("display control test done");
	endtask : t_disp

	// configuration streams, one surplus byte on the clock stream
	task automatic t_streams();
		host.stream(8'hA4, '{8'h10, 8'h32, 8'h54, 8'h76, 8'hAB, 8'hEE, 8'h20, 8'h70});
		chk(segment_map_q, 48'hEEAB76543210);
		chk(clock_fmt_q, 3'h2);
		chk({display_on_q, dim_code_q}, 4'h5);
		host.stream(8'hA2, '{8'h01, 8'h80, 8'h5A});
		chk(panel_hotkeys_q, 24'h5A8001);
		host.stream(8'hA1, '{8'h01, 8'h01, 8'h0C, 8'h02});
		chk(remote_count_q, 5'h04);
		chk(remote_hotkeys_q[31:0], 32'h020C0101);
		$display("stream test done");
	endtask : t_streams

	// address command, auto increment, fixed address and the clock window
	task automatic t_addr();
		host.put(8'hC5, 1'b1);
		chk(mem_addr_q, 6'h05);
		chk(clock_space_q, 1'b1);
		host.put(8'h40, 1'b1);
		host.put(8'h11, 1'b0);
		chk(mem_addr_q, 6'h06);
		host.put(8'hCF, 1'b1);
		host.put(8'h22, 1'b0);
		host.put(8'h33, 1'b0);
		chk(mem_addr_q, 6'h11);
		chk(clock_space_q, 1'b0);
		host.put(8'h44, 1'b1);
		host.put(8'h55, 1'b0);
		chk(mem_addr_q, 6'h11);
		$display("address test done");
	endtask : t_addr

	// hang guard, 50000 cycles, far above the run of about 110 cycles
	initial begin
		#5000000;
		miscompares++;
		test_done();
	end

	// reset for 8 cycles, then the scenarios
	initial begin
		resetn = 1'b0;
		repeat (8) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		t_reset();
		t_data();
		t_test();
		t_disp();
		t_streams();
		t_addr();
		test_done();
	end
endmodule : panel_command_decoder_tb
